// [design/scc_top.sv]
// Standby and system clock controller logic
//
// Strobed register access was decided locally.
module scc_top
    import scc_pkg::*;
#(
    parameter logic [1:0] WT_RESET = 2'h3,
    parameter bit POR_OPTION = 1'b1,
    parameter logic [18:0] WT_SCALE_11 = SCC_WT_11,
    parameter logic [15:0] SUB_WAIT = SCC_SUB_WAIT
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic sclk_tick_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic irq_pend_i,
    input wire logic [1:0] irq_level_i,
    input wire logic ext_irq_i,
    input wire logic [1:0] ext_irq_level_i,
    input wire logic ext_reset_i,
    output logic cpu_reset_o,
    output logic cycle_tick_o,
    output logic main_sel_o,
    output logic resume_o,
    output scc_ctl_t ctl_o
);
    //--------------------------------------------------------------
    // Input synchronisers
    //--------------------------------------------------------------
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {ext_reset_i, ext_irq_i, sclk_tick_i};
            sync2_q <= sync1_q;
        end
    end
    logic sub_tick;
    logic ext_irq_s;
    logic ext_rst_s;
    assign sub_tick = sync2_q[0];
    assign ext_irq_s = sync2_q[1];
    assign ext_rst_s = sync2_q[2];

    //--------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------
    scc_state_t state_q;
    logic spl_q;
    logic scs_q;
    logic [1:0] wt_q;
    logic [1:0] cs_q;
    logic main_q;
    logic wt_init_q;
    logic wr_system_clock_ctrl;
    logic wr_standby_ctrl;
    assign wr_system_clock_ctrl = wr_i && addr_i == SCC_SYSTEM_CLOCK_CTRL_ADDR;
    assign wr_standby_ctrl = wr_i && addr_i == SCC_STANDBY_CTRL_ADDR;

    // Build-time reset value, loaded after release
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wt_init_q <= 1'b0;
            wt_q <= 2'h0;
        end else if (!wt_init_q) begin
            wt_init_q <= 1'b1;
            wt_q <= WT_RESET;
        end else if (wr_system_clock_ctrl) begin
            wt_q <= wdata_i[SCC_WT_LO+1:SCC_WT_LO];
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scs_q <= 1'b1;
            cs_q <= 2'h0;
        end else if (cpu_reset_o) begin
            scs_q <= 1'b1;
            cs_q <= 2'h0;
        end else if (wr_system_clock_ctrl) begin
            scs_q <= wdata_i[SCC_SCS_BIT];
            cs_q <= wdata_i[SCC_CS_LO+1:SCC_CS_LO];
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            spl_q <= 1'b0;
        end else if (cpu_reset_o) begin
            spl_q <= 1'b0;
        end else if (wr_standby_ctrl) begin
            spl_q <= wdata_i[SCC_SPL_BIT];
        end
    end

    // Request bits read 0, reset bit reads 1
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i && addr_i == SCC_SYSTEM_CLOCK_CTRL_ADDR) begin
            rdata_o <= {main_q, 2'h0, wt_q, scs_q, cs_q};
        end else if (rd_i && addr_i == SCC_STANDBY_CTRL_ADDR) begin
            rdata_o <= {2'h0, spl_q, 1'b1, 4'h0};
        end else begin
            rdata_o <= 8'h00;
        end
    end

    //--------------------------------------------------------------
    // Stabilization wait counter
    //--------------------------------------------------------------
    // Wait length by select code
    logic [18:0] wait_len;
    always_comb begin
        unique case (wt_q)
            2'h3: wait_len = WT_SCALE_11;
            2'h2: wait_len = SCC_WT_10;
            2'h1: wait_len = SCC_WT_01;
            2'h0: wait_len = SCC_WT_00;
        endcase
    end

    logic [18:0] wcnt_q;
    logic wait_run_q;
    logic wait_start;
    logic wait_done;
    assign wait_done = wait_run_q && wcnt_q == 19'h00001;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wcnt_q <= 19'h00000;
            wait_run_q <= 1'b0;
        end else if (wait_start) begin
            wcnt_q <= wait_len;
            wait_run_q <= 1'b1;
        end else if (wait_run_q) begin
            wcnt_q <= wcnt_q - 19'h00001;
            wait_run_q <= !wait_done;
        end
    end

    // Fixed subclock restart wait, counted in subclock ticks
    logic [15:0] scnt_q;
    logic sub_ready;
    logic sub_osc_on;
    logic sub_tick_q;
    assign sub_ready = scnt_q == 16'h0000;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scnt_q <= 16'h0000;
            sub_tick_q <= 1'b0;
        end else begin
            sub_tick_q <= sub_tick;
            if (!sub_osc_on) begin
                scnt_q <= SUB_WAIT;
            end else if (!sub_ready && sub_tick && !sub_tick_q) begin
                scnt_q <= scnt_q - 16'h0001;
            end
        end
    end

    //--------------------------------------------------------------
    // Mode state machine
    //--------------------------------------------------------------
    logic stp_wr;
    logic slp_wr;
    logic tmd_wr;
    logic sw_rst;
    logic any_wake;
    logic ext_wake;
    logic stop_from_sub_q;
    logic osc_for_reset_q;
    logic [2:0] rcnt_q;
    assign stp_wr = wr_standby_ctrl && wdata_i[SCC_STP_BIT];
    assign slp_wr = wr_standby_ctrl && wdata_i[SCC_SLP_BIT];
    assign tmd_wr = wr_standby_ctrl && wdata_i[SCC_TMD_BIT] && !scs_q;
    assign sw_rst = wr_standby_ctrl && !wdata_i[SCC_RST_BIT];
    // Any resource interrupt above lowest level
    assign any_wake = irq_pend_i && irq_level_i != SCC_IL_NONE;
    assign ext_wake = ext_irq_s && ext_irq_level_i != SCC_IL_NONE;

    // Main clock switch: start wait when main selected but not running
    assign wait_start = !wait_run_q && (
        (state_q == SCC_RUN && scs_q && !main_q) ||
        (state_q == SCC_STOP && (ext_wake || ext_rst_s) && !stop_from_sub_q
            && POR_OPTION) ||
        (state_q == SCC_WATCH && ext_rst_s && POR_OPTION) ||
        (state_q == SCC_RUN && sw_rst && !main_q));

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= SCC_RUN;
            stop_from_sub_q <= 1'b0;
            osc_for_reset_q <= 1'b0;
        end else begin
            unique case (state_q)
                SCC_RUN: begin
                    if (sw_rst && !main_q) begin
                        state_q <= SCC_OSCW;
                        osc_for_reset_q <= 1'b1;
                    end else if (!irq_pend_i && stp_wr) begin
                        state_q <= SCC_STOP;
                        stop_from_sub_q <= !main_q;
                    end else if (!irq_pend_i && slp_wr) begin
                        state_q <= SCC_SLEEP;
                    end else if (!irq_pend_i && tmd_wr) begin
                        state_q <= SCC_WATCH;
                    end
                end
                SCC_SLEEP: begin
                    if (any_wake || ext_rst_s) begin
                        state_q <= SCC_RUN;
                    end
                end
                SCC_WATCH: begin
                    if (ext_rst_s && POR_OPTION) begin
                        state_q <= SCC_OSCW;
                        osc_for_reset_q <= 1'b1;
                    end else if (any_wake || ext_rst_s) begin
                        state_q <= SCC_RUN;
                    end
                end
                SCC_STOP: begin
                    if (ext_rst_s && POR_OPTION) begin
                        state_q <= SCC_OSCW;
                        osc_for_reset_q <= 1'b1;
                    end else if (ext_wake && !stop_from_sub_q) begin
                        state_q <= SCC_OSCW;
                        osc_for_reset_q <= 1'b0;
                    end else if (ext_wake || ext_rst_s) begin
                        state_q <= SCC_RUN;
                    end
                end
                SCC_OSCW: begin
                    if (wait_done) begin
                        state_q <= SCC_RUN;
                        osc_for_reset_q <= 1'b0;
                    end
                end
                default: state_q <= SCC_RUN;
            endcase
        end
    end

    // Main selected only after wait elapses
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            main_q <= 1'b1;
        end else if (!scs_q && state_q == SCC_RUN && !sw_rst) begin
            main_q <= 1'b0;
        end else if (wait_done && (scs_q || osc_for_reset_q)) begin
            main_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rcnt_q <= 3'h0;
        end else if (sw_rst && state_q == SCC_RUN && main_q) begin
            rcnt_q <= SCC_SWRST_CYC;
        end else if (rcnt_q != 3'h0) begin
            rcnt_q <= rcnt_q - 3'h1;
        end
    end

    //--------------------------------------------------------------
    // Instruction cycle divider
    //--------------------------------------------------------------
    // Divider period by code
    logic [6:0] div_len;
    logic [6:0] dcnt_q;
    always_comb begin
        unique case (cs_q)
            2'h0: div_len = SCC_DIV_00;
            2'h1: div_len = SCC_DIV_01;
            2'h2: div_len = SCC_DIV_10;
            2'h3: div_len = SCC_DIV_11;
        endcase
    end
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dcnt_q <= 7'h00;
            cycle_tick_o <= 1'b0;
        end else if (main_q) begin
            cycle_tick_o <= dcnt_q == 7'h00;
            dcnt_q <= dcnt_q == 7'h00 ? div_len - 7'h01 : dcnt_q - 7'h01;
        end else begin
            dcnt_q <= 7'h00;
            cycle_tick_o <= sub_tick && !sub_tick_q;
        end
    end

    //--------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------
    logic low_pin;
    assign low_pin = state_q == SCC_WATCH || state_q == SCC_STOP;
    // Subclock stops only in stop entered from subclock
    assign sub_osc_on = !(state_q == SCC_STOP && stop_from_sub_q);
    assign cpu_reset_o = rcnt_q != 3'h0 ||
        (state_q == SCC_OSCW && osc_for_reset_q);
    // Resume pulse back to CPU after interrupt wake, except from stop entered from main
    assign resume_o = state_q != SCC_RUN && state_q != SCC_OSCW &&
        !ext_rst_s && (state_q == SCC_STOP ? ext_wake && stop_from_sub_q
        : any_wake);
    assign main_sel_o = main_q;
    always_comb begin
        ctl_o.cpu_clk_en = state_q == SCC_RUN && sub_ready;
        ctl_o.periph_clk_en = state_q == SCC_RUN || state_q == SCC_SLEEP;
        // Watch keeps prescaler and wake logic
        ctl_o.watch_clk_en = sub_osc_on;
        ctl_o.main_osc_en = state_q == SCC_OSCW || (scs_q &&
            state_q != SCC_STOP && state_q != SCC_WATCH);
        ctl_o.sub_osc_en = sub_osc_on;
        ctl_o.pins_float = low_pin && spl_q;
        ctl_o.pins_hold = low_pin && !spl_q;
    end

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    sequence swr_write_s;
        sw_rst && state_q == SCC_RUN && main_q;
    endsequence
    swrst_len_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        swr_write_s |=> cpu_reset_o [*4] ##1 !cpu_reset_o)
        else $error("software reset not four cycles");
    block_entry_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        state_q == SCC_RUN && irq_pend_i && !sw_rst |=> state_q == SCC_RUN)
        else $error("low power entered with interrupt pending");
    watch_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        state_q == SCC_RUN && scs_q |=> state_q != SCC_WATCH)
        else $error("watch entered on main clock");
    pin_float_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        low_pin |-> ctl_o.pins_float == spl_q && ctl_o.pins_hold == !spl_q)
        else $error("pin state mismatch");
    sleep_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        state_q == SCC_SLEEP |-> !ctl_o.cpu_clk_en && ctl_o.periph_clk_en)
        else $error("sleep clock gating wrong");
    stop_wake_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        state_q == SCC_STOP && !ext_wake && !ext_rst_s |=> state_q == SCC_STOP)
        else $error("stop left without external cause");
    sub_osc_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $fell(main_q) |-> ##1 !ctl_o.main_osc_en || state_q == SCC_OSCW)
        else $error("main oscillator left on in subclock mode");
    main_wait_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $rose(main_q) |-> $past(wait_done))
        else $error("main clock taken before wait");
    monitor_rd_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        rd_i && addr_i == SCC_SYSTEM_CLOCK_CTRL_ADDR |=> rdata_o[SCC_STP_BIT] == $past(main_q))
        else $error("clock monitor readback wrong");
endmodule : scc_top

// [design/scc_pkg.sv]
// Package of constants and types for the standby clock controller
//------------------------------------------------------------------
// Behaviour
//------------------------------------------------------------------
// Behaviour
// - Stop request bit 7 enters stop mode, self clears, reads 0.
// - Sleep request bit 6 enters sleep mode, self clears, reads 0.
// - Pin float select 1 floats pins in watch/stop, else hold level.
// - Writing 0 to software reset bit gives four-cycle reset; reads 1.
// - Software reset from subclock holds reset through one stabilization wait.
// - Watch request accepted only with subclock selected; clears on interrupt.
// - Clock source monitor reads 1 on main clock, 0 on subclock.
// - Wait select codes 11,10,01,00 give 2^18,2^16,2^12,2^4 main periods.
// - Switch to main clock only after the selected stabilization wait.
// - Wait select reset value is a build option; software avoids rewriting.
// - Clock select 0 picks subclock, 1 picks main clock.
// - Divider codes 00,01,10,11 give cycles of 64,16,8,4 main periods.
// - Main oscillator stops while subclock mode is selected.
// - Sleep gates only the CPU clock; peripherals keep running.
// - Watch halts all but watch prescaler, external interrupt, wake-up.
// - Pending interrupt at request write blocks low-power entry.
// - Sleep and watch exit on reset or interrupt above level 11.
// - Stop exits on reset or external interrupt above level 11 only.
// - After wake-up CPU services interrupt or resumes next instruction.
// - Stop from main keeps subclock; stop from subclock stops both.
// - Reset ending stop or watch waits main stabilization first; after stop from subclock the wait never starts and reset stays high.
// - Without power-on reset option that stabilization wait is skipped.
// - Subclock stabilization is fixed at 2^15 subclock periods.
package scc_pkg;
    localparam logic [7:0] SCC_SYSTEM_CLOCK_CTRL_ADDR = 8'h07;
    localparam logic [7:0] SCC_STANDBY_CTRL_ADDR = 8'h08;
    localparam int SCC_STP_BIT = 7;
    localparam int SCC_SLP_BIT = 6;
    localparam int SCC_SPL_BIT = 5;
    localparam int SCC_RST_BIT = 4;
    localparam int SCC_TMD_BIT = 3;
    localparam int SCC_SCS_BIT = 2;
    localparam int SCC_CS_LO = 0;
    localparam int SCC_WT_LO = 3;
    localparam logic [2:0] SCC_SWRST_CYC = 3'h4;
    localparam logic [1:0] SCC_IL_NONE = 2'h3;
    localparam int SCC_WT_W = 19;
    localparam logic [18:0] SCC_WT_11 = 19'h40000;
    localparam logic [18:0] SCC_WT_10 = 19'h10000;
    localparam logic [18:0] SCC_WT_01 = 19'h01000;
    localparam logic [18:0] SCC_WT_00 = 19'h00010;
    localparam logic [15:0] SCC_SUB_WAIT = 16'h8000;
    localparam logic [6:0] SCC_DIV_00 = 7'h40;
    localparam logic [6:0] SCC_DIV_01 = 7'h10;
    localparam logic [6:0] SCC_DIV_10 = 7'h08;
    localparam logic [6:0] SCC_DIV_11 = 7'h04;

    typedef enum logic [2:0] {
        SCC_RUN = 3'b000,
        SCC_SLEEP = 3'b001,
        SCC_WATCH = 3'b010,
        SCC_STOP = 3'b011,
        SCC_OSCW = 3'b100
    } scc_state_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic watch_clk_en;
        logic main_osc_en;
        logic sub_osc_en;
        logic pins_float;
        logic pins_hold;
    } scc_ctl_t;
endpackage : scc_pkg

// [sim/scc_irq_model.sv]
// Behavioural CPU and interrupt controller facing the clock controller
module scc_irq_model import scc_pkg::*; (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic cpu_reset_i,
    input wire logic resume_i,
    input wire logic req_i,
    input wire logic ext_i,
    input wire logic clr_i,
    input wire logic [1:0] level_i,
    output logic irq_pend_o,
    output logic [1:0] irq_level_o,
    output logic ext_irq_o,
    output logic [1:0] ext_level_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // One process owns every output; bench strobes post or drop requests
    // Serviced or reset resource request is dropped
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_pend_o <= 1'b0;
            irq_level_o <= SCC_IL_NONE;
            ext_irq_o <= 1'b0;
            ext_level_o <= SCC_IL_NONE;
        end else if (clr_i) begin
            irq_pend_o <= 1'b0;
            irq_level_o <= SCC_IL_NONE;
            ext_irq_o <= 1'b0;
            ext_level_o <= SCC_IL_NONE;
        end else begin
            if (req_i) begin
                irq_pend_o <= 1'b1;
                irq_level_o <= level_i;
            end else if (resume_i === 1'b1 || cpu_reset_i === 1'b1) begin
                irq_pend_o <= 1'b0;
                irq_level_o <= SCC_IL_NONE;
            end
            if (ext_i) begin
                ext_irq_o <= 1'b1;
                ext_level_o <= level_i;
            end
        end
    end
endmodule : scc_irq_model

// [sim/tb_top.sv]
// Self-checking testbench for the standby clock controller
module tb_top;
    import scc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic sclk = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic pend, ext, cpu_rst, tick, msel, resume;
    logic [1:0] lvl, ext_lvl;
    logic irq_req = 1'b0;
    logic irq_ext = 1'b0;
    logic irq_clr = 1'b0;
    logic [1:0] irq_lvl = SCC_IL_NONE;
    logic ext_rst = 1'b0;
    scc_ctl_t ctl;
    int mismatches = 0;
    int check_count = 0;
    int n;
    logic [6:0] divs [4] = '{SCC_DIV_00, SCC_DIV_01, SCC_DIV_10, SCC_DIV_11};

    scc_top #(.WT_SCALE_11(19'h00020), .SUB_WAIT(16'h0004)) u_dut (
        .mclk_i(mclk), .rstn_i(rstn), .sclk_tick_i(sclk), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .irq_pend_i(pend), .irq_level_i(lvl), .ext_irq_i(ext),
        .ext_irq_level_i(ext_lvl), .ext_reset_i(ext_rst),
        .cpu_reset_o(cpu_rst), .cycle_tick_o(tick), .main_sel_o(msel),
        .resume_o(resume), .ctl_o(ctl)
    );

    scc_irq_model u_irq (
        .mclk_i(mclk), .rstn_i(rstn), .cpu_reset_i(cpu_rst),
        .resume_i(resume), .req_i(irq_req), .ext_i(irq_ext),
        .clr_i(irq_clr), .level_i(irq_lvl), .irq_pend_o(pend),
        .irq_level_o(lvl), .ext_irq_o(ext), .ext_level_o(ext_lvl)
    );

    initial begin
        forever #2 mclk = ~mclk;
    end

    // Subclock scaled down; halts while its oscillator is off
    initial begin
        forever begin
            #80;
            if (ctl.sub_osc_en !== 1'b0) begin
                sclk = ~sclk;
            end
        end
    end

    //----------------------------------------------------------------
    // Tasks
    //----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        check({24'h0, rdata}, {24'h0, exp});
    endtask : rd_reg

    function automatic logic sig(input int s);
        case (s)
            0: return tick;
            1: return msel;
            default: return ctl.cpu_clk_en;
        endcase
    endfunction : sig

    // Bounded wait, counts edges until the chosen output reaches v
    task automatic wait_for(input int s, input logic v, output int k);
        k = 0;
        while (sig(s) !== v && k < 3000) begin
            @(posedge mclk);
            #1;
            k++;
        end
    endtask : wait_for

    // Strobe bits {clear, external, resource} to the partner model
    task automatic irq(input logic [2:0] what, input logic [1:0] l);
        @(posedge mclk);
        {irq_clr, irq_ext, irq_req} <= what;
        irq_lvl <= l;
        @(posedge mclk);
        {irq_clr, irq_ext, irq_req} <= 3'h0;
    endtask : irq

    // Cycles with the CPU reset high over a fixed window
    task automatic count_rst(input int cycles, output int k);
        k = 0;
        repeat (cycles) begin
            #1;
            k += cpu_rst;
            @(posedge mclk);
        end
    endtask : count_rst

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    initial begin
        #300000;
        mismatches++;
        summarize();
    end

    //----------------------------------------------------------------
    // Tests
    //----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        repeat (2) @(posedge mclk);
        rd_reg(SCC_SYSTEM_CLOCK_CTRL_ADDR, 8'h9C);
        rd_reg(SCC_STANDBY_CTRL_ADDR, 8'h10);
        rd_reg(8'h09, 8'h00);
        wr_reg(SCC_STANDBY_CTRL_ADDR, 8'h30);
        rd_reg(SCC_STANDBY_CTRL_ADDR, 8'h30);
        wr_reg(SCC_STANDBY_CTRL_ADDR, 8'h10);
        // Instruction cycle per divider code, old period skipped
        for (int c = 0; c < 4; c++) begin
            wr_reg(SCC_SYSTEM_CLOCK_CTRL_ADDR, 8'h1C | c[7:0]);
            repeat (2) begin
                wait_for(0, 1'b1, n);
                @(posedge mclk);
                #1;
            end
            wait_for(0, 1'b1, n);
            check(n + 1, {25'h0, divs[c]});
        end
        wr_reg(SCC_STANDBY_CTRL_ADDR, 8'h00);
        count_rst(8, n);
        check(n, {29'h0, SCC_SWRST_CYC});
        // Sleep refused while a request is pending, then taken
        irq(3'h1, 2'h1);
        wr_reg(SCC_STANDBY_CTRL_ADDR, 8'h50);
        repeat (3) @(posedge mclk);
        check(ctl.cpu_clk_en, 1'b1);
        irq(3'h4, SCC_IL_NONE);
        wr_reg(SCC_STANDBY_CTRL_ADDR, 8'h50);
        wait_for(2, 1'b0, n);
        check(ctl.periph_clk_en, 1'b1);
        irq(3'h1, SCC_IL_NONE);
        repeat (6) @(posedge mclk);
        check(ctl.cpu_clk_en, 1'b0);
        irq(3'h1, 2'h1);
        wait_for(2, 1'b1, n);
        check(n <= 4, 1'b1);
        irq(3'h4, SCC_IL_NONE);
        rd_reg(SCC_STANDBY_CTRL_ADDR, 8'h10);
        wr_reg(SCC_STANDBY_CTRL_ADDR, 8'h18);
        repeat (3) @(posedge mclk);
        check({ctl.cpu_clk_en, ctl.periph_clk_en}, 2'h3);
        // Stop from main with floating pins
        wr_reg(SCC_STANDBY_CTRL_ADDR, 8'hB0);
        wait_for(2, 1'b0, n);
        check({ctl.main_osc_en, ctl.sub_osc_en}, 2'h1);
        check(ctl.pins_float, 1'b1);
        irq(3'h1, 2'h0);
        repeat (12) @(posedge mclk);
        check(ctl.cpu_clk_en, 1'b0);
        irq(3'h2, 2'h1);
        wait_for(2, 1'b1, n);
        check(n >= 32 && n <= 48, 1'b1);
        irq(3'h4, SCC_IL_NONE);
        rd_reg(SCC_STANDBY_CTRL_ADDR, 8'h30);
        wr_reg(SCC_STANDBY_CTRL_ADDR, 8'h10);
        // Wait code changed only while running main
        wr_reg(SCC_SYSTEM_CLOCK_CTRL_ADDR, 8'h1C);
        wr_reg(SCC_SYSTEM_CLOCK_CTRL_ADDR, 8'h00);
        @(posedge mclk);
        #1;
        check(msel, 1'b0);
        rd_reg(SCC_SYSTEM_CLOCK_CTRL_ADDR, 8'h00);
        check(ctl.main_osc_en, 1'b0);
        wr_reg(SCC_STANDBY_CTRL_ADDR, 8'h18);
        wait_for(2, 1'b0, n);
        check({ctl.periph_clk_en, ctl.watch_clk_en}, 2'h1);
        check({ctl.pins_hold, ctl.pins_float}, 2'h2);
        irq(3'h1, 2'h0);
        wait_for(2, 1'b1, n);
        check(n <= 4, 1'b1);
        rd_reg(SCC_STANDBY_CTRL_ADDR, 8'h10);
        wr_reg(SCC_SYSTEM_CLOCK_CTRL_ADDR, 8'h04);
        // Monitor awaited after switching to main
        wait_for(1, 1'b1, n);
        check(n >= 16 && n <= 24, 1'b1);
        rd_reg(SCC_SYSTEM_CLOCK_CTRL_ADDR, 8'h84);
        // External reset out of watch holds reset through the wait
        wr_reg(SCC_SYSTEM_CLOCK_CTRL_ADDR, 8'h00);
        wr_reg(SCC_STANDBY_CTRL_ADDR, 8'h18);
        wait_for(2, 1'b0, n);
        @(posedge mclk);
        ext_rst <= 1'b1;
        @(posedge mclk);
        ext_rst <= 1'b0;
        count_rst(32, n);
        check(n, {13'h0, SCC_WT_00});
        check(msel, 1'b1);
        // Stop from subclock stops both oscillators
        wr_reg(SCC_SYSTEM_CLOCK_CTRL_ADDR, 8'h00);
        wr_reg(SCC_STANDBY_CTRL_ADDR, 8'h90);
        wait_for(2, 1'b0, n);
        check({ctl.main_osc_en, ctl.sub_osc_en}, 2'h0);
        irq(3'h2, 2'h1);
        wait_for(2, 1'b1, n);
        check(n >= 120 && n <= 170, 1'b1);
        irq(3'h4, SCC_IL_NONE);
        // Software reset on subclock lasts one main wait
        wr_reg(SCC_STANDBY_CTRL_ADDR, 8'h00);
        count_rst(24, n);
        check(n, {13'h0, SCC_WT_00});
        rd_reg(SCC_SYSTEM_CLOCK_CTRL_ADDR, 8'h84);
        summarize();
    end
endmodule : tb_top
